// ==== core/ifc_pkg.sv ====
// package: register map, field layout and state record of the interrupt flag and edge block
package ifc_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int          DATA_W          = 16;
  localparam int          NUM_EXT         = 5;
  localparam int          REG_ADDR_W      = 4;

  // ****************************************************************
  // register indices on the register port
  // ****************************************************************
  localparam logic [3:0]  REG_CONTROL_TWO = 4'h0;
  localparam logic [3:0]  REG_FLAGS_ZERO  = 4'h1;
  localparam logic [3:0]  REG_FLAGS_ONE   = 4'h2;
  localparam logic [3:0]  REG_FLAGS_TWO   = 4'h3;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int          ALT_TABLE_BIT   = 15;
  localparam int          HOLD_ACTIVE_BIT = 14;
  localparam int          EXT0_FLAG_BIT   = 0;
  localparam int          EXT1_FLAG_BIT   = 4;
  localparam int          EXT2_FLAG_BIT   = 13;

  // ****************************************************************
  // implemented bits and values after reset
  // ****************************************************************
  localparam logic [15:0] CONTROL_WR_MASK = 16'h801F;
  localparam logic [15:0] FLAGS_ZERO_MASK = 16'h7FFF;
  localparam logic [15:0] FLAGS_ONE_MASK  = 16'hFFFB;
  localparam logic [15:0] FLAGS_TWO_MASK  = 16'hDFFF;
  localparam logic [15:0] REG_RESET_VALUE = 16'h0000;
  localparam logic [4:0]  EXT_RESET_VALUE = 5'h00;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [15:0] flags_two;
    logic [15:0] flags_one;
    logic [15:0] flags_zero;
  } ifc_events_s;

  typedef struct packed {
    logic [15:0]        control_two;
    logic [15:0]        flags_zero;
    logic [15:0]        flags_one;
    logic [15:0]        flags_two;
    logic [NUM_EXT-1:0] sync_first;
    logic [NUM_EXT-1:0] sync_second;
    logic [NUM_EXT-1:0] sync_prev;
    logic [NUM_EXT-1:0] edge_pulse;
    logic [15:0]        rdata;
  } ifc_state_s;

endpackage

// ==== core/ifc_flag_edge_ctl.sv ====
// interrupt request flag capture, external pin edge select and vector table control
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module ifc_flag_edge_ctl
  import ifc_pkg::*;
#(
  parameter int ADDR_W = REG_ADDR_W
) (
  input  wire logic               i_clock,                  // system clock, 25 MHz
  input  wire logic               i_rstn,                   // async reset, active low
  input  wire logic [ADDR_W-1:0]  i_addr,                   // register index
  input  wire logic [15:0]        i_wdata,                  // write data
  input  wire logic               i_wr,                     // write strobe
  input  wire logic               i_rd,                     // read strobe
  output logic      [15:0]        o_rdata,                  // read data, cycle after strobe
  input  wire ifc_events_s        i_periph_events,          // peripheral request pulses
  input  wire logic [NUM_EXT-1:0] i_ext_irq,                // external interrupt pins
  input  wire logic               i_hold_active,            // interrupt-disable in effect
  output logic                    o_alt_vector_table_select,// alternate table in use
  output logic      [NUM_EXT-1:0] o_ext_polarity,           // per-pin polarity select
  output logic      [NUM_EXT-1:0] o_ext_edge,               // detected pin edge pulse
  output logic      [15:0]        o_flags_zero,             // flag register zero
  output logic      [15:0]        o_flags_one,              // flag register one
  output logic      [15:0]        o_flags_two               // flag register two
);

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (ADDR_W < 2 || ADDR_W > REG_ADDR_W) begin : g_bad_addr
    $error("ADDR_W must lie between 2 and REG_ADDR_W");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [3:0]        idx);
    addr_hit = (addr == ADDR_W'(idx));
  endfunction

  // hardware set is applied after the software write so it wins
  function automatic logic [15:0] flag_update(input logic [15:0] old_val,
                                              input logic [15:0] set_val,
                                              input logic        wr_hit,
                                              input logic [15:0] wdata,
                                              input logic [15:0] mask);
    logic [15:0] base;
    base = wr_hit ? wdata : old_val;
    flag_update = (base | set_val) & mask;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  ifc_state_s         st_reg;
  ifc_state_s         st_next;
  logic [NUM_EXT-1:0] edge_now;
  logic [15:0]        set_zero;
  logic [15:0]        set_one;
  logic [15:0]        set_two;
  logic [15:0]        control_view;
  logic               wr_control;
  logic               wr_zero;
  logic               wr_one;
  logic               wr_two;

  always_comb begin
    st_next = st_reg;
    wr_control = i_wr && addr_hit(i_addr, REG_CONTROL_TWO);
    wr_zero    = i_wr && addr_hit(i_addr, REG_FLAGS_ZERO);
    wr_one     = i_wr && addr_hit(i_addr, REG_FLAGS_ONE);
    wr_two     = i_wr && addr_hit(i_addr, REG_FLAGS_TWO);

    // two-stage synchroniser, then a history stage for edge detection
    st_next.sync_first  = i_ext_irq;
    st_next.sync_second = st_reg.sync_first;
    st_next.sync_prev   = st_reg.sync_second;

    // edge is judged on pin history under the current polarity select, so a polarity flip alone never fires
    for (int i = 0; i < NUM_EXT; i++) begin
      if (st_reg.control_two[i]) begin
        edge_now[i] = st_reg.sync_prev[i] & ~st_reg.sync_second[i];
      end else begin
        edge_now[i] = ~st_reg.sync_prev[i] & st_reg.sync_second[i];
      end
    end
    st_next.edge_pulse = edge_now;

    // map sources onto their flag positions
    set_zero                = i_periph_events.flags_zero;
    set_zero[EXT0_FLAG_BIT] = edge_now[0];
    set_one                 = i_periph_events.flags_one;
    set_one[EXT1_FLAG_BIT]  = edge_now[1];
    set_one[EXT2_FLAG_BIT]  = edge_now[2];
    set_two                 = i_periph_events.flags_two;

    if (wr_control) begin
      st_next.control_two = i_wdata & CONTROL_WR_MASK;
    end
    st_next.flags_zero = flag_update(st_reg.flags_zero, set_zero, wr_zero,
                                     i_wdata, FLAGS_ZERO_MASK);
    st_next.flags_one  = flag_update(st_reg.flags_one, set_one, wr_one,
                                     i_wdata, FLAGS_ONE_MASK);
    st_next.flags_two  = flag_update(st_reg.flags_two, set_two, wr_two,
                                     i_wdata, FLAGS_TWO_MASK);

    // status bit reflects the core at the moment of the read
    control_view                  = st_reg.control_two;
    control_view[HOLD_ACTIVE_BIT] = i_hold_active;

    st_next.rdata = REG_RESET_VALUE;
    if (i_rd) begin
      case (i_addr)
        ADDR_W'(REG_CONTROL_TWO): st_next.rdata = control_view;
        ADDR_W'(REG_FLAGS_ZERO):  st_next.rdata = st_reg.flags_zero;
        ADDR_W'(REG_FLAGS_ONE):   st_next.rdata = st_reg.flags_one;
        ADDR_W'(REG_FLAGS_TWO):   st_next.rdata = st_reg.flags_two;
        default:                  st_next.rdata = REG_RESET_VALUE;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg.control_two <= REG_RESET_VALUE;
      st_reg.flags_zero  <= REG_RESET_VALUE;
      st_reg.flags_one   <= REG_RESET_VALUE;
      st_reg.flags_two   <= REG_RESET_VALUE;
      st_reg.sync_first  <= EXT_RESET_VALUE;
      st_reg.sync_second <= EXT_RESET_VALUE;
      st_reg.sync_prev   <= EXT_RESET_VALUE;
      st_reg.edge_pulse  <= EXT_RESET_VALUE;
      st_reg.rdata       <= REG_RESET_VALUE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_rdata                   = st_reg.rdata;
  assign o_alt_vector_table_select = st_reg.control_two[ALT_TABLE_BIT];
  assign o_ext_polarity            = st_reg.control_two[NUM_EXT-1:0];
  assign o_ext_edge                = st_reg.edge_pulse;
  assign o_flags_zero              = st_reg.flags_zero;
  assign o_flags_one               = st_reg.flags_one;
  assign o_flags_two               = st_reg.flags_two;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);

  sequence s_write_control;
    i_wr && addr_hit(i_addr, REG_CONTROL_TWO);
  endsequence

  sequence s_read_control;
    i_rd && addr_hit(i_addr, REG_CONTROL_TWO);
  endsequence

  sequence s_pin0_rise_quiet_pol;
    ($rose(i_ext_irq[0]) && !st_reg.control_two[0])
      ##1 ($stable(i_ext_irq[0]) && !st_reg.control_two[0])[*2];
  endsequence

  sequence s_pin1_fall_quiet_pol;
    ($fell(i_ext_irq[1]) && st_reg.control_two[1])
      ##1 ($stable(i_ext_irq[1]) && st_reg.control_two[1])[*2];
  endsequence

  chk_alt_table_write: assert property (
    s_write_control |=> (o_alt_vector_table_select == $past(i_wdata[ALT_TABLE_BIT]))
  ) else $error("table select does not follow the written bit");

  chk_hold_status_read: assert property (
    s_read_control |=> (o_rdata[HOLD_ACTIVE_BIT] == $past(i_hold_active))
  ) else $error("hold status bit does not match the core at read time");

  chk_unused_bits_zero: assert property (
    s_read_control |=> (o_rdata[13:5] == 9'h000)
  ) else $error("unimplemented control bit reads non-zero");

  chk_flag_gaps_zero: assert property (
    (o_flags_one[2] == 1'h0) && (o_flags_two[13] == 1'h0) && (o_flags_zero[15] == 1'h0)
  ) else $error("unimplemented flag bit reads non-zero");

  chk_rise_edge_flag: assert property (
    s_pin0_rise_quiet_pol |=> (o_ext_edge[0] && o_flags_zero[EXT0_FLAG_BIT])
  ) else $error("rising edge on pin 0 did not raise its flag");

  chk_fall_edge_flag: assert property (
    s_pin1_fall_quiet_pol |=> (o_ext_edge[1] && o_flags_one[EXT1_FLAG_BIT])
  ) else $error("falling edge on pin 1 did not raise its flag");

  chk_event_sets_flag: assert property (
    i_periph_events.flags_two[2] |=> o_flags_two[2]
  ) else $error("source request did not set its flag");

  chk_set_beats_clear: assert property (
    (i_periph_events.flags_two[2] && i_wr && addr_hit(i_addr, REG_FLAGS_TWO)
     && !i_wdata[2]) |=> o_flags_two[2]
  ) else $error("software clear overrode a hardware set");

  chk_flag_sticky: assert property (
    (o_flags_one[15] && !(i_wr && addr_hit(i_addr, REG_FLAGS_ONE))) |=> o_flags_one[15]
  ) else $error("flag dropped without a software write");

  chk_flag_write: assert property (
    (i_wr && addr_hit(i_addr, REG_FLAGS_ONE) && (i_periph_events.flags_one == 16'h0000)
     && (edge_now == EXT_RESET_VALUE))
      |=> (o_flags_one == ($past(i_wdata) & FLAGS_ONE_MASK))
  ) else $error("flag register one does not hold the written value");

  chk_no_spurious_edge: assert property (
    ($stable(i_ext_irq[2]))[*4] |-> !o_ext_edge[2]
  ) else $error("edge reported while pin 2 stood still");

  chk_ext_edge_flags: assert property (
    o_ext_edge[2] |-> o_flags_one[EXT2_FLAG_BIT]
  ) else $error("pin 2 edge did not appear in flag register one");

  chk_read_one_cycle: assert property (
    !i_rd |=> (o_rdata == 16'h0000)
  ) else $error("read data present without a read strobe");

  // ****************************************************************
  // reset, control outputs and flag map
  // ****************************************************************
  chk_reset_clears: assert property (
    $rose(i_rstn) |-> ((o_flags_zero | o_flags_one | o_flags_two) == REG_RESET_VALUE)
                      && !o_alt_vector_table_select && (o_ext_polarity == EXT_RESET_VALUE)
  ) else $error("register not cleared by reset");

  chk_alt_table_hold: assert property (
    !(i_wr && addr_hit(i_addr, REG_CONTROL_TWO)) |=> $stable(o_alt_vector_table_select)
  ) else $error("table select moved without a control write");

  chk_polarity_write: assert property (
    s_write_control |=> (o_ext_polarity == $past(i_wdata[NUM_EXT-1:0]))
  ) else $error("polarity outputs do not follow the written bits");

  chk_event_map_zero: assert property (
    i_periph_events.flags_zero[14] |=> o_flags_zero[14]
  ) else $error("top source of flag register zero did not set its flag");

  chk_event_map_one: assert property (
    i_periph_events.flags_one[15] |=> o_flags_one[15]
  ) else $error("top source of flag register one did not set its flag");

  chk_event_map_two: assert property (
    i_periph_events.flags_two[15] |=> o_flags_two[15]
  ) else $error("top source of flag register two did not set its flag");

  chk_spi2_error_flag: assert property (
    i_periph_events.flags_two[0] |=> o_flags_two[0]
  ) else $error("lowest source of flag register two did not set its flag");

  // the pin 0 position belongs to the pin edge, never to the peripheral word
  chk_pin_owns_flag: assert property (
    (i_periph_events.flags_zero[EXT0_FLAG_BIT] && !edge_now[0] && !i_wr
     && !o_flags_zero[EXT0_FLAG_BIT]) |=> !o_flags_zero[EXT0_FLAG_BIT]
  ) else $error("peripheral input set the pin 0 flag position");

  chk_edge_one_cycle: assert property (
    o_ext_edge[0] |=> !o_ext_edge[0]
  ) else $error("pin 0 edge pulse lasted more than one cycle");

  chk_sync_latency: assert property (
    o_ext_edge[0] |-> ($past(i_ext_irq[0], 3) != $past(i_ext_irq[0], 4))
  ) else $error("pin 0 edge reported without the synchroniser delay");

  chk_read_flags_zero: assert property (
    (i_rd && addr_hit(i_addr, REG_FLAGS_ZERO)) |=> (o_rdata == $past(o_flags_zero))
  ) else $error("flag register zero read back a different value");

  chk_flag_two_write: assert property (
    (i_wr && addr_hit(i_addr, REG_FLAGS_TWO) && (i_periph_events.flags_two == 16'h0000))
      |=> (o_flags_two == ($past(i_wdata) & FLAGS_TWO_MASK))
  ) else $error("flag register two does not hold the written value");

endmodule

`default_nettype wire

// ==== verification/ifc_far_side.sv ====
// far side model: peripheral request sources, external pins and cpu disable status
`timescale 1ns/10ps
`default_nettype none

module ifc_far_side
  import ifc_pkg::*;
(
  input  wire logic               i_clock,       // system clock
  output var  ifc_events_s        o_events,      // peripheral request pulses
  output var  logic [NUM_EXT-1:0] o_ext_irq,     // external pin levels
  output var  logic               o_hold_active  // disable instruction in effect
);
  initial begin
    o_events      = '0;
    o_ext_irq     = '0;
    o_hold_active = 1'b0;
  end

  // ****************************************************************
  // one-cycle request pulse, launched just after an edge
  // ****************************************************************
  task automatic pulse(input ifc_events_s ev);
    @(posedge i_clock);
    o_events <= ev;
    @(posedge i_clock);
    o_events <= '0;
  endtask

  // pins hold each level for many cycles so the synchroniser sees it
  task automatic drive_pins(input logic [NUM_EXT-1:0] lvl);
    @(posedge i_clock);
    o_ext_irq <= lvl;
  endtask

  task automatic set_hold(input logic on);
    @(posedge i_clock);
    o_hold_active <= on;
  endtask
endmodule

`default_nettype wire

// ==== verification/tb_top.sv ====
// top testbench of the interrupt flag and edge block
`timescale 1ns/10ps
`default_nettype none

module tb_top
  import ifc_pkg::*;
;
  logic               i_clock;
  logic               i_rstn;
  logic [3:0]         i_addr;
  logic [15:0]        i_wdata;
  logic               i_wr;
  logic               i_rd;
  logic [15:0]        o_rdata;
  ifc_events_s        ev;
  logic [NUM_EXT-1:0] pins;
  logic               hold;
  logic               alt_sel;
  logic [NUM_EXT-1:0] pol;
  logic [NUM_EXT-1:0] edg;
  logic [15:0]        fz, fo, ft;
  int                 fails, num_checks, cycles;

  ifc_flag_edge_ctl dut (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_periph_events(ev),
    .i_ext_irq(pins), .i_hold_active(hold), .o_alt_vector_table_select(alt_sel),
    .o_ext_polarity(pol), .o_ext_edge(edg), .o_flags_zero(fz), .o_flags_one(fo),
    .o_flags_two(ft));

  ifc_far_side far (.i_clock(i_clock), .o_events(ev), .o_ext_irq(pins),
    .o_hold_active(hold));

  // ****************************************************************
  // clock, hang guard, summary and check helper
  // ****************************************************************
  always #20 i_clock = ~i_clock;

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ****************************************************************
  // register port
  // ****************************************************************
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clock);
    i_wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string name);
    @(posedge i_clock);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    #1;
    chk(name, o_rdata, exp);
  endtask

  // drives pins, then gathers which pins pulsed an edge
  task automatic pin_step(input logic [4:0] lvl, input logic [4:0] exp);
    logic [4:0] seen;
    seen = '0;
    far.drive_pins(lvl);
    repeat (7) begin
      @(posedge i_clock);
      #1;
      seen |= edg;
    end
    chk("edge mask", {11'h000, seen}, {11'h000, exp});
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rd_chk(REG_CONTROL_TWO, 16'h0000, "control");
    rd_chk(REG_FLAGS_ZERO, 16'h0000, "flags0");
    rd_chk(REG_FLAGS_ONE, 16'h0000, "flags1");
    rd_chk(REG_FLAGS_TWO, 16'h0000, "flags2");
  endtask

  task automatic t_control();
    wr(REG_CONTROL_TWO, 16'hFFFF);
    rd_chk(REG_CONTROL_TWO, 16'h801F, "control");
    chk("alt port", {15'h0000, alt_sel}, 16'h0001);
    chk("pol port", {11'h000, pol}, 16'h001F);
    far.set_hold(1'b1);
    rd_chk(REG_CONTROL_TWO, 16'hC01F, "hold on");
    far.set_hold(1'b0);
    wr(REG_CONTROL_TWO, 16'h0000);
    rd_chk(REG_CONTROL_TWO, 16'h0000, "control clr");
    chk("alt port", {15'h0000, alt_sel}, 16'h0000);
    wr(4'h7, 16'hFFFF);
    rd_chk(4'h7, 16'h0000, "unmapped");
  endtask

  task automatic t_flags_sw();
    wr(REG_FLAGS_ZERO, 16'hFFFF);
    wr(REG_FLAGS_ONE, 16'hFFFF);
    wr(REG_FLAGS_TWO, 16'hFFFF);
    rd_chk(REG_FLAGS_ZERO, 16'h7FFF, "flags0");
    rd_chk(REG_FLAGS_ONE, 16'hFFFB, "flags1");
    rd_chk(REG_FLAGS_TWO, 16'hDFFF, "flags2");
    wr(REG_FLAGS_ZERO, 16'h0000);
    wr(REG_FLAGS_ONE, 16'h0000);
    wr(REG_FLAGS_TWO, 16'h0000);
    #1;
    chk("flags0 port", fz | fo | ft, 16'h0000);
  endtask

  task automatic t_events();
    far.pulse('{16'hFFFF, 16'hFFFF, 16'hFFFF});
    repeat (3) @(posedge i_clock);
    rd_chk(REG_FLAGS_ZERO, 16'h7FFE, "ev flags0");
    rd_chk(REG_FLAGS_ONE, 16'hDFEB, "ev flags1");
    rd_chk(REG_FLAGS_TWO, 16'hDFFF, "ev flags2");
    fork
      wr(REG_FLAGS_TWO, 16'h0000);
      far.pulse('{16'h0004, 16'h0000, 16'h0000});
    join
    rd_chk(REG_FLAGS_TWO, 16'h0004, "set wins");
    wr(REG_FLAGS_ZERO, 16'h0000);
    wr(REG_FLAGS_ONE, 16'h0000);
    wr(REG_FLAGS_TWO, 16'h0000);
  endtask

  task automatic t_pins();
    pin_step(5'h1F, 5'h1F);
    chk("pin flags0", fz, 16'h0001);
    chk("pin flags1", fo, 16'h2010);
    pin_step(5'h00, 5'h00);
    wr(REG_CONTROL_TWO, 16'h001F);
    pin_step(5'h00, 5'h00);
    pin_step(5'h1F, 5'h00);
    pin_step(5'h00, 5'h1F);
    wr(REG_CONTROL_TWO, 16'h0000);
    pin_step(5'h00, 5'h00);
  endtask

  // reset in mid-run with every register loaded
  task automatic t_mid_reset();
    wr(REG_CONTROL_TWO, 16'h801F);
    far.pulse('{16'hDFFF, 16'hFFFB, 16'h7FFF});
    @(posedge i_clock);
    i_rstn <= 1'h0;
    repeat (2) @(posedge i_clock);
    #1;
    chk("rst flags", fz | fo | ft, 16'h0000);
    chk("rst ctl ports", {10'h000, alt_sel, pol}, 16'h0000);
    i_rstn <= 1'h1;
    t_reset();
  endtask

  initial begin
    i_clock = 1'b0;
    i_rstn  = 1'b0;
    i_addr  = '0;
    i_wdata = '0;
    i_wr    = 1'b0;
    i_rd    = 1'b0;
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
    t_reset();
    t_control();
    t_flags_sw();
    t_events();
    t_pins();
    t_mid_reset();
    wrap_up();
  end
endmodule

`default_nettype wire
